/* logic/aeb_pkg.sv */
// constants and carrier types for the exchange bus memory master
package aeb_pkg;

  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // microcycle of six steps
  localparam int unsigned STEP_COUNT   = 6;
  localparam logic [2:0]  STEP_LAST    = 3'h5;
  localparam logic [2:0]  STEP_IO      = 3'h3;
  localparam logic [2:0]  STEP_RESET   = 3'h0;
  // settle time between ordered handshake edges, in ns
  localparam int unsigned SETTLE_NS    = 50;
  localparam int unsigned SETTLE_CYC   =
    ((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  SETTLE_CNT   = 4'(SETTLE_CYC);
  localparam logic [15:0] ADDR_RESET   = 16'h0000;
  localparam logic [15:0] DATA_RESET   = 16'h0000;
  localparam logic [7:0]  CMD_RESET    = 8'h00;

  // handshake outputs to the bus
  typedef struct packed {
    logic attn;       // cycle strobe
    logic mem_sel;    // space select, high for memory
    logic store;      // write/read qualifier, high while writing
    logic drive;      // transceiver direction, high while driving
  } aeb_hs_t;

  // core request for one memory cycle
  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } aeb_req_t;

endpackage

/* logic/aeb_sync3.sv */
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
module aeb_sync3
(
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic pin,
  output logic      level
);

  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // change taken once second and third stages agree
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      level <= 1'b0;
    else if (s2 == s3)
      level <= s3;
  end

endmodule

/* logic/aeb_master.sv */
// memory read/write master for the shared system bus
`timescale 1ns/1ps
// Behaviour
// RQ1 - read: select, qualifier, address, then strobe
// RQ2 - read ack: drop address, drop direction
// RQ3 - read ack low: latch, strobe, then select
// RQ4 - memory holds data until strobe falls
// RQ5 - write: qualifier, select, direction, address, strobe
// RQ6 - write ack: stop driving address
// RQ7 - write: data out, then drop qualifier
// RQ8 - memory stores on qualifier fall, drops ack
// RQ9 - write end: strobe, then release, select
// RQ10 - handshake steps wait on events only (setup and write data steps wait on the settle count)
// RQ11 - outputs steer transceivers directly
// RQ12 - lines 15..0 address, 7..0 data (code drives and latches data on all 16 lines)
// RQ13 - all masters share same read sequence
// RQ14 - program counter to both operand buses
// RQ15 - read data onto both operand buses
// RQ16 - two-phase clock, six-step microcycle
// RQ17 - fixed steps, stretched for bus I/O
// RQ18 - requester waits for grant
// RQ19 - requester holds request whole operation
// RQ20 - acknowledge synchronised before use
// RQ21 - reset: handshake low, lines released
module aeb_master
(
  input  wire logic            core_clk,
  input  wire logic            rst_b,
  input  wire logic            req_valid,
  input  wire aeb_pkg::aeb_req_t req,
  output logic                 req_done,
  output logic [15:0]          a_bus,
  output logic [15:0]          b_bus,
  output logic                 phase_1,
  output logic                 phase_2,
  output logic [2:0]           step,
  input  wire logic            bus_prio_req,
  output logic                 bus_granted,
  input  wire logic            ack_in,
  input  wire logic [15:0]     bus_in,
  output logic [15:0]          bus_out,
  output logic                 bus_oe,
  output aeb_pkg::aeb_hs_t     hs
);

  typedef enum logic [3:0] {
    AEB_IDLE,
    AEB_SETUP,
    AEB_STROBE,
    AEB_WAIT_ACK,
    AEB_RD_WAIT_DROP,
    AEB_RD_END_SEL,
    AEB_WR_DATA,
    AEB_WR_WAIT_DROP,
    AEB_WR_RELEASE
  } aeb_state_t;

  aeb_state_t  state;
  logic        ack;
  logic        prio;
  logic        is_write;
  logic [15:0] wdata;
  logic [3:0]  settle;
  logic        settled;
  logic        io_hold;
  logic        take;
  // =====================================================
  // input synchronisers
  // =====================================================
  // RQ20 - synchronised acknowledge
  aeb_sync3 u_ack_sync
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pin      (ack_in),
    .level    (ack)
  );

  aeb_sync3 u_prio_sync
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pin      (bus_prio_req),
    .level    (prio)
  );
  // =====================================================
  // microcycle sequencer
  // =====================================================
  // RQ18 - no cycle while another master holds bus
  assign take = (state == AEB_IDLE) && req_valid && !prio && !bus_granted && !ack
                && (step == aeb_pkg::STEP_IO);
  // step 3 held from the taking edge on, so a cycle never starts on the way out
  assign io_hold = (step == aeb_pkg::STEP_IO) && ((state != AEB_IDLE) || take);
  // RQ16 - six steps, two phases
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      step    <= aeb_pkg::STEP_RESET;
      phase_1 <= 1'b1;
      phase_2 <= 1'b0;
    end
    else
    begin
      phase_1 <= ~phase_1;
      phase_2 <= phase_1;
      // RQ17 - stretch for bus I/O
      if (!io_hold && phase_2)
        step <= (step == aeb_pkg::STEP_LAST) ? aeb_pkg::STEP_RESET : step + 3'h1;
    end
  end
  // =====================================================
  // bus grant to other masters
  // =====================================================
  // RQ19 - stay off bus while request held
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      bus_granted <= 1'b0;
    else if (state == AEB_IDLE)
      bus_granted <= prio;
  end
  // =====================================================
  // settle counter between ordered edges
  // =====================================================
  assign settled = (settle == 4'h0);
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      settle <= 4'h0;
    else if (state == AEB_SETUP || state == AEB_WR_DATA)
      settle <= settled ? 4'h0 : settle - 4'h1;
    else
      settle <= aeb_pkg::SETTLE_CNT;
  end
  // =====================================================
  // handshake state machine
  // =====================================================
  // RQ10 - ack steps wait on ack, setup and write data steps on the settle count, the others take one cycle
  // RQ13 - same sequence for any master
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state    <= AEB_IDLE;
      is_write <= 1'b0;
      wdata    <= aeb_pkg::DATA_RESET;
    end
    else
    begin
      case (state)
        AEB_IDLE:
          if (take)
          begin
            is_write <= req.write;
            wdata    <= req.wdata;
            state    <= AEB_SETUP;
          end
        AEB_SETUP:
          if (settled)
            state <= AEB_STROBE;
        AEB_STROBE: state <= AEB_WAIT_ACK;
        AEB_WAIT_ACK:
          if (ack)
            state <= is_write ? AEB_WR_DATA : AEB_RD_WAIT_DROP;
        AEB_RD_WAIT_DROP:
          if (!ack)
            state <= AEB_RD_END_SEL;
        AEB_RD_END_SEL: state <= AEB_IDLE;
        AEB_WR_DATA:
          if (settled)
            state <= AEB_WR_WAIT_DROP;
        AEB_WR_WAIT_DROP:
          if (!ack)
            state <= AEB_WR_RELEASE;
        AEB_WR_RELEASE: state <= AEB_IDLE;
        default: state <= AEB_IDLE;
      endcase
    end
  end
  // =====================================================
  // handshake outputs
  // =====================================================
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      // RQ21 - handshake idle after reset
      hs <= '0;
    else
    begin
      case (state)
        AEB_IDLE:
          // RQ1 - select and qualifier before strobe
          // RQ5 - direction with address on write
          if (take)
          begin
            hs.mem_sel <= 1'b1;
            hs.store   <= req.write;
            hs.drive   <= 1'b1;
          end
        AEB_STROBE: hs.attn <= 1'b1;
        AEB_WAIT_ACK:
          // RQ2 - read ack drops direction
          if (ack && !is_write)
            hs.drive <= 1'b0;
        AEB_WR_DATA:
          // RQ7 - qualifier falls after data settles
          if (settled)
            hs.store <= 1'b0;
        AEB_RD_WAIT_DROP,
        AEB_WR_WAIT_DROP:
          // RQ3 - strobe first once ack gone
          // RQ9 - strobe first on write too
          if (!ack)
            hs.attn <= 1'b0;
        AEB_RD_END_SEL: hs.mem_sel <= 1'b0;
        AEB_WR_RELEASE:
        begin
          hs.mem_sel <= 1'b0;
          hs.drive   <= 1'b0;
        end
        default: hs <= hs;
      endcase
    end
  end
  // =====================================================
  // bus lines
  // =====================================================
  // RQ11 - oe follows drive, outputs wire to transceivers
  // RQ12 - full 16-bit address, full 16-bit data on the same lines
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus_out <= aeb_pkg::DATA_RESET;
      bus_oe  <= 1'b0;
    end
    else
    begin
      case (state)
        AEB_IDLE:
          if (take)
          begin
            bus_out <= req.addr;
            bus_oe  <= 1'b1;
          end
        AEB_WAIT_ACK:
          // RQ2 - address off on read ack
          // RQ6 - address replaced by write data
          if (ack)
          begin
            bus_out <= is_write ? wdata : aeb_pkg::DATA_RESET;
            bus_oe  <= is_write;
          end
        AEB_WR_RELEASE:
        begin
          // RQ9 - release with select and direction
          bus_out <= aeb_pkg::DATA_RESET;
          bus_oe  <= 1'b0;
        end
        default: bus_oe <= bus_oe;
      endcase
    end
  end
  // =====================================================
  // operand buses and completion
  // =====================================================
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      a_bus    <= aeb_pkg::DATA_RESET;
      b_bus    <= aeb_pkg::DATA_RESET;
      req_done <= 1'b0;
    end
    else
    begin
      req_done <= (state == AEB_RD_END_SEL) || (state == AEB_WR_RELEASE);
      if (take)
      begin
        // RQ14 - address on both operand buses
        a_bus <= req.addr;
        b_bus <= req.addr;
      end
      else if (state == AEB_RD_WAIT_DROP && !ack)
      begin
        // RQ3 - latch data as ack drops
        // RQ4 - memory still drives until strobe falls
        // RQ15 - read data on both operand buses
        a_bus <= bus_in;
        b_bus <= bus_in;
      end
    end
  end

endmodule

/* verif/aeb_checker.sv */
// assertion checker for the exchange bus memory master
`timescale 1ns/1ps
module aeb_checker
(
  input wire logic             core_clk,
  input wire logic             rst_b,
  input wire logic             ack_in,
  input wire logic [15:0]      a_bus,
  input wire logic [15:0]      b_bus,
  input wire logic [15:0]      bus_in,
  input wire logic [15:0]      bus_out,
  input wire logic             bus_oe,
  input wire logic [2:0]       step,
  input wire logic             phase_1,
  input wire logic             phase_2,
  input wire logic             bus_granted,
  input wire aeb_pkg::aeb_hs_t hs
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ====================
  // handshake order
  attn_order_a:
  assert property ($rose(hs.attn) |-> $past(hs.mem_sel) && $past(bus_oe))
    else $error("strobe too early");
  rd_release_a:
  assert property ($fell(hs.drive) && hs.attn |-> !bus_oe)
    else $error("address kept on bus");
  rd_wait_a:
  assert property ($rose(ack_in) && hs.attn && !hs.store |=> $stable(hs) ##[1:6] !hs.drive)
    else $error("ack reaction wrong");
  sel_last_a:
  assert property ($fell(hs.mem_sel) |-> !$past(hs.attn))
    else $error("select before strobe");
  rd_latch_a:
  assert property ($fell(hs.attn) && !hs.drive |-> a_bus == $past(bus_in) && b_bus == a_bus)
    else $error("read data not latched");
  wr_qual_a:
  assert property ($fell(hs.store) && hs.mem_sel |-> bus_oe && $stable(bus_out))
    else $error("qualifier before data");
  wr_end_a:
  assert property ($fell(hs.attn) && hs.drive |-> bus_oe ##1 !(bus_oe || hs.mem_sel || hs.drive))
    else $error("write end order");
  addr_out_a:
  assert property ($rose(hs.mem_sel) |-> bus_oe && a_bus == bus_out && b_bus == bus_out)
    else $error("address not on buses");
  io_step_a:
  assert property (hs.attn |-> step == aeb_pkg::STEP_IO)
    else $error("step moved in bus cycle");
  phase_split_a:
  assert property ((phase_1 ^ phase_2) && step <= aeb_pkg::STEP_LAST)
    else $error("phases overlap or step out of range");
  step_pace_a:
  assert property ($changed(step) |-> $past(phase_2))
    else $error("step moved without phase two");
  reset_idle_a:
  assert property (disable iff (1'b0) !rst_b |-> {hs, bus_oe} == 5'h00)
    else $error("not idle in reset");
  cover property ($fell(hs.attn) && !hs.drive);
  cover property ($fell(hs.attn) && hs.drive);
  cover property ($rose(bus_granted));
endmodule
bind aeb_master aeb_checker u_chk (.core_clk, .rst_b, .ack_in, .a_bus, .b_bus, .bus_in,
  .bus_out, .bus_oe, .step, .phase_1, .phase_2, .bus_granted, .hs);

/* verif/aeb_mem_model.sv */
// behavioural memory on the far side of the shared system bus
`timescale 1ns/1ps
module aeb_mem_model
(
  input  wire logic             core_clk,
  input  wire aeb_pkg::aeb_hs_t hs,
  input  wire logic [15:0]      bus_in,
  input  wire logic [3:0]       lag,
  output logic                  ack_in,
  output logic                  mem_oe,
  output logic [15:0]           mem_q
);
  logic [15:0] mem [0:255];
  logic [7:0]  addr;
  initial
  begin
    ack_in = 1'b0;
    mem_oe = 1'b0;
    mem_q  = 16'h0000;
    forever
    begin
      @(posedge core_clk iff (hs.attn && hs.mem_sel));
      addr = bus_in[7:0];
      repeat (lag) @(posedge core_clk);
      ack_in <= 1'b1;
      if (!hs.store)
      begin
        @(posedge core_clk iff !hs.drive);
        mem_q  <= mem[addr];
        mem_oe <= 1'b1;
        repeat (lag) @(posedge core_clk);
        ack_in <= 1'b0;
        @(posedge core_clk iff !hs.attn);
        mem_oe <= 1'b0;
      end
      else
      begin
        @(posedge core_clk iff !hs.store);
        mem[addr] = bus_in;
        repeat (lag) @(posedge core_clk);
        ack_in <= 1'b0;
        @(posedge core_clk iff !hs.attn);
      end
    end
  end
endmodule

/* verif/aeb_master_tb.sv */
// self-checking bench for the exchange bus memory master
`timescale 1ns/1ps
module aeb_master_tb;
  logic              core_clk;
  logic              rst_b;
  logic              req_valid;
  aeb_pkg::aeb_req_t req;
  logic              req_done;
  logic [15:0]       a_bus;
  logic [15:0]       b_bus;
  logic [2:0]        step;
  logic              bus_prio_req;
  logic              bus_granted;
  logic              ack_in;
  logic [15:0]       bus_in;
  logic [15:0]       bus_out;
  logic              bus_oe;
  aeb_pkg::aeb_hs_t  hs;
  logic              mem_oe;
  logic [15:0]       mem_q;
  logic [15:0]       last;
  logic [3:0]        lag;
  logic [16:0]       notes [$];
  logic [16:0]       note;
  logic [15:0]       shadow [0:255];
  logic [15:0]       a;
  int                fail_count;
  int                checks;
  int                i;
  int                n;
  // released lines show a pattern that changes every cycle
  always @(posedge core_clk) last <= bus_in;
  assign bus_in = bus_oe ? bus_out : (mem_oe ? mem_q : ~last);
  aeb_master dut (.core_clk, .rst_b, .req_valid, .req, .req_done, .a_bus, .b_bus,
    .phase_1(), .phase_2(), .step, .bus_prio_req, .bus_granted, .ack_in, .bus_in,
    .bus_out, .bus_oe, .hs);
  aeb_mem_model u_mem (.core_clk, .hs, .bus_in, .lag, .ack_in, .mem_oe, .mem_q);
  initial
  begin
    core_clk = 1'b0;
    forever
      #25 core_clk = ~core_clk;
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task start(input logic w, input logic [15:0] ad, input logic [15:0] d);
    @(negedge core_clk);
    req_valid = 1'b1;
    req = '{write: w, addr: ad, wdata: d};
    if (w)
      shadow[ad[7:0]] = d;
    notes.push_back({!w, shadow[ad[7:0]]});
  endtask
  task finish;
    for (n = 0; n < 300 && req_done !== 1'b1; n++)
      @(negedge core_clk);
    if (n == 300)
    begin
      fail_count++;
      final_report;
    end
    else
      req_valid = 1'b0;
  endtask
  // ====================
  // result monitor
  always @(negedge core_clk)
    if (req_done === 1'b1)
    begin
      note = notes.pop_front();
      if (note[16])
      begin
        check(a_bus, note[15:0]);
        check(b_bus, note[15:0]);
      end
    end
  // ====================
  // main sequence
  initial
  begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req = '0;
    bus_prio_req = 1'b0;
    lag = 4'h0;
    last = 16'h0000;
    fail_count = 0;
    checks = 0;
    void'($urandom(68036));
    repeat (2) @(negedge core_clk);
    check({11'h000, hs, bus_oe}, 16'h0000);
    rst_b = 1'b1;
    for (i = 0; i < 12; i++)
    begin
      lag = 4'(i % 3 * 3);
      a = {8'($urandom), 8'(i)};
      start(1'b1, a, 16'($urandom));
      finish;
      start(1'b0, a, 16'h0000);
      finish;
    end
    start(1'b0, a, 16'h0000);
    finish;
    bus_prio_req = 1'b1;
    repeat (6) @(negedge core_clk);
    start(1'b0, a, 16'h0000);
    repeat (20) @(negedge core_clk);
    check({15'h0000, bus_granted}, 16'h0001);
    check({15'h0000, hs.attn}, 16'h0000);
    bus_prio_req = 1'b0;
    finish;
    final_report;
  end
endmodule
